// *** rtl/flash_opcode_decoder.sv ***
// captures the first serial byte of each chip-select frame and decodes it
// What this block does
// - 03 is plain fetch, selectable address; 13 plain fetch, four bytes; 50 MHz.
// - 0B is fast fetch, selectable address; 0C four-byte variant; up to 133 MHz.
// - 6B is quad-output fetch, selectable address; 6C four-byte variant; 104 MHz.
// - EB is quad io fetch, selectable address; EC four-byte variant; 104 MHz.
// - ED is dual-rate quad io fetch; EE four-byte variant; 80 MHz.
// - 02 is page write, selectable address; 12 four-byte variant; 133 MHz.
// - 32 and 38 are quad page write; 34 four-byte variant; 80 MHz.
// - 20 wipes one 8 KB parameter block; 21 same with four-byte address.
// - D8 wipes a 128 KB or 512 KB block; DC same with four bytes.
// - 30 clears status and the erase and program fail flags.
// - 43 stores the non-volatile training pattern register.
// - 4A writes the volatile training pattern register.
// - 41 reads back the training pattern for sampling-point calibration.
// - 90 reads the maker signature; up to 133 MHz.
// - 9F reads the jedec identifier followed by flash interface data.
// - A3 stays reserved for the multi io fast mode; no other meaning.
// - B9 means bank register access, not deep power down.
module flash_opcode_decoder #(
  parameter int FIFO_DEPTH = flash_cmd_pkg::FIFO_DEPTH
) (
  input  wire logic            sys_clk_in,
  input  wire logic            reset_n_in,
  input  wire logic            cs_n_in,
  input  wire logic            sck_in,
  input  wire logic            si_in,
  output logic                 cmd_valid_out,
  input  wire logic            cmd_ready_in,
  output flash_cmd_pkg::decode_t cmd_out,
  output logic                 ignored_pulse_out,
  output logic                 drop_pulse_out,
  output logic                 busy_out
);

  localparam int SN = flash_cmd_pkg::SYNC_STAGES;
  localparam int RN = flash_cmd_pkg::RESET_STAGES;
  localparam int OB = flash_cmd_pkg::OPCODE_BITS;
  localparam logic [2:0] LAST_BIT = 3'(OB - 1);

  typedef enum logic [1:0] {
    ph_idle   = 2'b00,
    ph_opcode = 2'b01,
    ph_ignore = 2'b10
  } phase_t;

  typedef struct packed {
    logic [SN-1:0]          sel_sync;
    logic [SN-1:0]          sck_sync;
    logic [SN-1:0]          si_sync;
    logic                   sel_f;
    logic                   sck_f;
    logic                   si_f;
    phase_t                 phase;
    logic [2:0]             bit_cnt;
    logic [OB-1:0]          shreg;
    logic                   pend;
    flash_cmd_pkg::decode_t pend_cmd;
    logic                   ignored;
    logic                   drop;
  } state_t;

  logic [RN-1:0] rst_sync_r;
  logic          rst_n;
  state_t        s_r;
  state_t        s_nxt;
  logic          fifo_in_ready;

  // a level counts once the second and third stages agree
  function automatic logic filt(input logic [SN-1:0] sync, input logic prev);
    filt = (sync[1] == sync[2]) ? sync[2] : prev;
  endfunction : filt

  function automatic logic listed_other(input logic [OB-1:0] op);
    listed_other = 1'b0;
    for (int i = 0; i < flash_cmd_pkg::OTHER_COUNT; i++)
    begin
      if (flash_cmd_pkg::OTHER_OPS[i] == op)
      begin
        listed_other = 1'b1;
      end
    end
  endfunction : listed_other

  function automatic flash_cmd_pkg::decode_t decode_op(input logic [OB-1:0] op);
    flash_cmd_pkg::decode_t d;
    d.opcode = op;
    d.cls    = flash_cmd_pkg::cls_unlisted;
    d.addr   = flash_cmd_pkg::addr_none;
    d.clk    = flash_cmd_pkg::clk_133;
    case (op)
      flash_cmd_pkg::OP_PLAIN_FETCH, flash_cmd_pkg::OP_PLAIN_FETCH_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_plain_fetch;
        d.clk  = flash_cmd_pkg::clk_50;
        d.addr = (op == flash_cmd_pkg::OP_PLAIN_FETCH_4B) ? flash_cmd_pkg::addr_four
                                                          : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_FAST_FETCH, flash_cmd_pkg::OP_FAST_FETCH_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_fast_fetch;
        d.addr = (op == flash_cmd_pkg::OP_FAST_FETCH_4B) ? flash_cmd_pkg::addr_four
                                                         : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_QUAD_OUT_FETCH, flash_cmd_pkg::OP_QUAD_OUT_FETCH_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_quad_out_fetch;
        d.clk  = flash_cmd_pkg::clk_104;
        d.addr = (op == flash_cmd_pkg::OP_QUAD_OUT_FETCH_4B) ? flash_cmd_pkg::addr_four
                                                             : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_QUAD_IO_FETCH, flash_cmd_pkg::OP_QUAD_IO_FETCH_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_quad_io_fetch;
        d.clk  = flash_cmd_pkg::clk_104;
        d.addr = (op == flash_cmd_pkg::OP_QUAD_IO_FETCH_4B) ? flash_cmd_pkg::addr_four
                                                            : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_DUAL_RATE_QUAD_IO_FETCH, flash_cmd_pkg::OP_DUAL_RATE_QUAD_IO_FETCH_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_dual_rate_quad_io_fetch;
        d.clk  = flash_cmd_pkg::clk_80;
        d.addr = (op == flash_cmd_pkg::OP_DUAL_RATE_QUAD_IO_FETCH_4B)
                 ? flash_cmd_pkg::addr_four : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_PAGE_WRITE, flash_cmd_pkg::OP_PAGE_WRITE_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_page_write;
        d.addr = (op == flash_cmd_pkg::OP_PAGE_WRITE_4B) ? flash_cmd_pkg::addr_four
                                                         : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_QUAD_PAGE_WRITE, flash_cmd_pkg::OP_QUAD_PAGE_WRITE_ALT,
      flash_cmd_pkg::OP_QUAD_PAGE_WRITE_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_quad_page_write;
        d.clk  = flash_cmd_pkg::clk_80;
        d.addr = (op == flash_cmd_pkg::OP_QUAD_PAGE_WRITE_4B) ? flash_cmd_pkg::addr_four
                                                              : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_PARAM_BLOCK_WIPE, flash_cmd_pkg::OP_PARAM_BLOCK_WIPE_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_param_block_wipe;
        d.addr = (op == flash_cmd_pkg::OP_PARAM_BLOCK_WIPE_4B) ? flash_cmd_pkg::addr_four
                                                               : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_LARGE_BLOCK_WIPE, flash_cmd_pkg::OP_LARGE_BLOCK_WIPE_4B:
      begin
        d.cls  = flash_cmd_pkg::cls_large_block_wipe;
        d.addr = (op == flash_cmd_pkg::OP_LARGE_BLOCK_WIPE_4B) ? flash_cmd_pkg::addr_four
                                                               : flash_cmd_pkg::addr_sel;
      end
      flash_cmd_pkg::OP_BULK_WIPE, flash_cmd_pkg::OP_BULK_WIPE_ALT:
      begin
        d.cls = flash_cmd_pkg::cls_bulk_wipe;
      end
      flash_cmd_pkg::OP_CLEAR_FAIL_FLAGS:
      begin
        d.cls = flash_cmd_pkg::cls_clear_fail_flags;
      end
      flash_cmd_pkg::OP_NV_TRAIN_PATTERN_STORE:
      begin
        d.cls = flash_cmd_pkg::cls_nv_train_pattern_store;
      end
      flash_cmd_pkg::OP_VOL_TRAIN_PATTERN_STORE:
      begin
        d.cls = flash_cmd_pkg::cls_vol_train_pattern_store;
      end
      flash_cmd_pkg::OP_TRAIN_PATTERN_FETCH:
      begin
        d.cls = flash_cmd_pkg::cls_train_pattern_fetch;
      end
      flash_cmd_pkg::OP_MAKER_SIGNATURE_FETCH:
      begin
        d.cls = flash_cmd_pkg::cls_maker_signature_fetch;
      end
      flash_cmd_pkg::OP_JEDEC_IDENT_FETCH:
      begin
        d.cls = flash_cmd_pkg::cls_jedec_ident_fetch;
      end
      flash_cmd_pkg::OP_MULTI_IO_FAST_MODE:
      begin
        d.cls = flash_cmd_pkg::cls_multi_io_fast_mode;
      end
      flash_cmd_pkg::OP_BANK_REG_ACCESS_LEGACY:
      begin
        d.cls = flash_cmd_pkg::cls_bank_reg_access_legacy;
      end
      flash_cmd_pkg::OP_SLOW_SIGNATURE_FETCH:
      begin
        d.cls = flash_cmd_pkg::cls_other_listed;
        d.clk = flash_cmd_pkg::clk_50;
      end
      default:
      begin
        // unknown codes are reported at the slowest class to stay safe
        if (listed_other(op))
        begin
          d.cls = flash_cmd_pkg::cls_other_listed;
        end
        else
        begin
          d.clk = flash_cmd_pkg::clk_50;
        end
      end
    endcase
    decode_op = d;
  endfunction : decode_op

  function automatic logic is_ignored(input flash_cmd_pkg::cmd_class_t c);
    is_ignored = (c == flash_cmd_pkg::cls_unlisted) ||
                 (c == flash_cmd_pkg::cls_multi_io_fast_mode);
  endfunction : is_ignored

  // reset is released through two flops so every flop leaves reset together
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_sync_r <= '0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[RN-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[RN-1];

  always_comb
  begin
    logic                   sck_now;
    logic                   sck_rise;
    logic [OB-1:0]          byte_now;
    flash_cmd_pkg::decode_t dec;
    sck_now  = 1'b0;
    sck_rise = 1'b0;
    byte_now = '0;
    dec      = decode_op('0);
    s_nxt    = s_r;
    s_nxt.ignored  = 1'b0;
    s_nxt.drop     = 1'b0;
    // select is kept active high inside so the all-zero reset means idle
    s_nxt.sel_sync = {s_r.sel_sync[SN-2:0], ~cs_n_in};
    s_nxt.sck_sync = {s_r.sck_sync[SN-2:0], sck_in};
    s_nxt.si_sync  = {s_r.si_sync[SN-2:0], si_in};
    s_nxt.sel_f    = filt(s_r.sel_sync, s_r.sel_f);
    s_nxt.si_f     = filt(s_r.si_sync, s_r.si_f);
    sck_now        = filt(s_r.sck_sync, s_r.sck_f);
    s_nxt.sck_f    = sck_now;
    sck_rise       = sck_now & ~s_r.sck_f;
    if (s_r.pend & fifo_in_ready)
    begin
      s_nxt.pend = 1'b0;
    end
    case (s_r.phase)
      ph_idle:
      begin
        if (s_nxt.sel_f)
        begin
          s_nxt.phase   = ph_opcode;
          s_nxt.bit_cnt = '0;
        end
      end
      ph_opcode:
      begin
        // a frame cut short before eight bits yields nothing
        if (!s_nxt.sel_f)
        begin
          s_nxt.phase = ph_idle;
        end
        else if (sck_rise)
        begin
          byte_now      = {s_r.shreg[OB-2:0], s_nxt.si_f};
          s_nxt.shreg   = byte_now;
          s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
          if (s_r.bit_cnt == LAST_BIT)
          begin
            dec         = decode_op(byte_now);
            s_nxt.phase = ph_ignore;
            if (is_ignored(dec.cls))
            begin
              s_nxt.ignored = 1'b1;
            end
            else if (s_r.pend & ~fifo_in_ready)
            begin
              // sink stalled with one record already waiting: newest is lost
              s_nxt.drop = 1'b1;
            end
            else
            begin
              s_nxt.pend     = 1'b1;
              s_nxt.pend_cmd = dec;
            end
          end
        end
      end
      ph_ignore:
      begin
        if (!s_nxt.sel_f)
        begin
          s_nxt.phase = ph_idle;
        end
      end
      default:
      begin
        s_nxt.phase = ph_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  cmd_fifo #(
    .WIDTH ($bits(flash_cmd_pkg::decode_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n),
    .in_valid_in   (s_r.pend),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (s_r.pend_cmd),
    .out_valid_out (cmd_valid_out),
    .out_ready_in  (cmd_ready_in),
    .out_data_out  (cmd_out)
  );

  assign ignored_pulse_out = s_r.ignored;
  assign drop_pulse_out    = s_r.drop;
  assign busy_out          = (s_r.phase != ph_idle);

endmodule : flash_opcode_decoder

// *** rtl/flash_cmd_pkg.sv ***
// opcode values, decoded command classes and the record passed downstream
package flash_cmd_pkg;

  localparam int OPCODE_BITS  = 8;
  localparam int SYNC_STAGES  = 3;
  localparam int RESET_STAGES = 2;
  localparam int FIFO_DEPTH   = 8;

  // classes of decoded commands
  typedef enum logic [4:0] {
    cls_unlisted                = 5'h00,
    cls_plain_fetch             = 5'h01,
    cls_fast_fetch              = 5'h02,
    cls_quad_out_fetch          = 5'h03,
    cls_quad_io_fetch           = 5'h04,
    cls_dual_rate_quad_io_fetch = 5'h05,
    cls_page_write              = 5'h06,
    cls_quad_page_write         = 5'h07,
    cls_param_block_wipe        = 5'h08,
    cls_large_block_wipe        = 5'h09,
    cls_bulk_wipe               = 5'h0A,
    cls_clear_fail_flags        = 5'h0B,
    cls_nv_train_pattern_store  = 5'h0C,
    cls_vol_train_pattern_store = 5'h0D,
    cls_train_pattern_fetch     = 5'h0E,
    cls_maker_signature_fetch   = 5'h0F,
    cls_jedec_ident_fetch       = 5'h10,
    cls_multi_io_fast_mode      = 5'h11,
    cls_bank_reg_access_legacy  = 5'h12,
    cls_other_listed            = 5'h13
  } cmd_class_t;

  // address length that follows the opcode
  typedef enum logic [1:0] {
    addr_none = 2'h0,
    addr_sel  = 2'h1,
    addr_four = 2'h2
  } addr_mode_t;

  // highest serial clock allowed for the command
  typedef enum logic [1:0] {
    clk_50  = 2'h0,
    clk_80  = 2'h1,
    clk_104 = 2'h2,
    clk_133 = 2'h3
  } clk_class_t;

  typedef struct packed {
    logic [OPCODE_BITS-1:0] opcode;
    cmd_class_t             cls;
    addr_mode_t             addr;
    clk_class_t             clk;
  } decode_t;

  localparam logic [7:0] OP_PLAIN_FETCH                = 8'h03;
  localparam logic [7:0] OP_PLAIN_FETCH_4B             = 8'h13;
  localparam logic [7:0] OP_FAST_FETCH                 = 8'h0B;
  localparam logic [7:0] OP_FAST_FETCH_4B              = 8'h0C;
  localparam logic [7:0] OP_QUAD_OUT_FETCH             = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT_FETCH_4B          = 8'h6C;
  localparam logic [7:0] OP_QUAD_IO_FETCH              = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_FETCH_4B           = 8'hEC;
  localparam logic [7:0] OP_DUAL_RATE_QUAD_IO_FETCH    = 8'hED;
  localparam logic [7:0] OP_DUAL_RATE_QUAD_IO_FETCH_4B = 8'hEE;
  localparam logic [7:0] OP_PAGE_WRITE                 = 8'h02;
  localparam logic [7:0] OP_PAGE_WRITE_4B              = 8'h12;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE            = 8'h32;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE_ALT        = 8'h38;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE_4B         = 8'h34;
  localparam logic [7:0] OP_PARAM_BLOCK_WIPE           = 8'h20;
  localparam logic [7:0] OP_PARAM_BLOCK_WIPE_4B        = 8'h21;
  localparam logic [7:0] OP_LARGE_BLOCK_WIPE           = 8'hD8;
  localparam logic [7:0] OP_LARGE_BLOCK_WIPE_4B        = 8'hDC;
  localparam logic [7:0] OP_BULK_WIPE                  = 8'h60;
  localparam logic [7:0] OP_BULK_WIPE_ALT              = 8'hC7;
  localparam logic [7:0] OP_CLEAR_FAIL_FLAGS           = 8'h30;
  localparam logic [7:0] OP_NV_TRAIN_PATTERN_STORE     = 8'h43;
  localparam logic [7:0] OP_VOL_TRAIN_PATTERN_STORE    = 8'h4A;
  localparam logic [7:0] OP_TRAIN_PATTERN_FETCH        = 8'h41;
  localparam logic [7:0] OP_MAKER_SIGNATURE_FETCH      = 8'h90;
  localparam logic [7:0] OP_JEDEC_IDENT_FETCH          = 8'h9F;
  localparam logic [7:0] OP_MULTI_IO_FAST_MODE         = 8'hA3;
  localparam logic [7:0] OP_BANK_REG_ACCESS_LEGACY     = 8'hB9;
  localparam logic [7:0] OP_SLOW_SIGNATURE_FETCH       = 8'hAB;

  // remaining listed commands, all limited to the fastest clock class
  localparam int OTHER_COUNT = 31;
  localparam logic [OTHER_COUNT-1:0][7:0] OTHER_OPS = {
    8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h18, 8'h2B, 8'h2F, 8'h35, 8'h42, 8'h4B, 8'h75,
    8'h7A, 8'h85, 8'h8A, 8'hA6, 8'hA7, 8'hE0, 8'hE1, 8'hE2,
    8'hE3, 8'hE4, 8'hE7, 8'hE8, 8'hE9, 8'hF0, 8'hFF
  };

endpackage : flash_cmd_pkg

// *** rtl/cmd_fifo.sv ***
// synchronous valid/ready fifo with parameterised width and depth
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        push;
  logic        pop;

  // wraps at any depth, not only powers of two
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction : next_ptr

  assign in_ready_out  = (st_r.count != FULL_CNT);
  assign out_valid_out = (st_r.count != '0);
  assign out_data_out  = st_r.mem[st_r.rd_ptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr_ptr] = in_data_in;
      st_nxt.wr_ptr           = next_ptr(st_r.wr_ptr);
    end
    if (pop)
    begin
      st_nxt.rd_ptr = next_ptr(st_r.rd_ptr);
    end
    if (push & ~pop)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
    else if (pop & ~push)
    begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : cmd_fifo

// *** tb/spi_host_model.sv ***
// host model driving chip select, serial clock and data
module spi_host_model (
  input  wire logic clk_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask : hold
  // mode 0, clock parked low between frames; 4+4 system cycles is 200 ns
  task automatic frame(input logic [15:0] bits, input int nb);
    hold(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      si_out = bits[15-i];
      hold(4);
      sck_out = 1'b1;
      hold(4);
      sck_out = 1'b0;
    end
    hold(4);
    cs_n_out = 1'b1;
    // released line must not keep the last bit
    si_out = ~si_out;
    hold(6);
  endtask : frame
endmodule : spi_host_model

// *** tb/flash_opcode_decoder_props.sv ***
// concurrent checks on the opcode decoder ports
module flash_opcode_decoder_props (
  input wire logic                   sys_clk_in,
  input wire logic                   reset_n_in,
  input wire logic                   cs_n_in,
  input wire logic                   sck_in,
  input wire logic                   si_in,
  input wire logic                   cmd_valid_out,
  input wire logic                   cmd_ready_in,
  input wire flash_cmd_pkg::decode_t cmd_out,
  input wire logic                   ignored_pulse_out,
  input wire logic                   drop_pulse_out,
  input wire logic                   busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] op;
  logic [4:0] cls;
  assign op  = cmd_out.opcode;
  assign cls = cmd_out.cls;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  valid_hold_a: assert property (cmd_valid_out && !cmd_ready_in |=> $stable(cmd_out))
    else $error("record changed before it was taken");
  ignored_once_a: assert property (ignored_pulse_out |=> !ignored_pulse_out)
    else $error("ignored pulse longer than one cycle");
  drop_once_a: assert property (drop_pulse_out |=> !drop_pulse_out)
    else $error("drop pulse longer than one cycle");
  busy_set_a: assert property (!cs_n_in [*6] |-> busy_out)
    else $error("busy missing during frame");
  busy_clear_a: assert property (cs_n_in [*8] |-> !busy_out)
    else $error("busy held after deselect");
  no_ignored_a: assert property (cmd_valid_out |-> cls != 5'h00 && cls != 5'h11)
    else $error("ignored class queued");
  plain_clk_a: assert property (cmd_valid_out && cls == 5'h01 |-> cmd_out.clk == 2'h0)
    else $error("plain fetch clock class wrong");
  dual_rate_a: assert property (cmd_valid_out && op inside {8'hED, 8'hEE} |->
    cls == 5'h05 && cmd_out.clk == 2'h1)
    else $error("dual rate fetch decode wrong");
  quad_write_a: assert property (cmd_valid_out && op inside {8'h32, 8'h38} |->
    cls == 5'h07 && cmd_out.addr == 2'h1)
    else $error("quad page write decode wrong");
  bank_access_a: assert property (cmd_valid_out && op == 8'hB9 |-> cls == 5'h12)
    else $error("bank access decode wrong");
  bulk_class_a: assert property (cmd_valid_out && op inside {8'h60, 8'hC7} |->
    cls == 5'h0A)
    else $error("bulk wipe class wrong");
  cover property (drop_pulse_out);
  cover property (ignored_pulse_out);
  cover property (cmd_valid_out && cmd_ready_in);
endmodule : flash_opcode_decoder_props
bind flash_opcode_decoder flash_opcode_decoder_props u_props (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .sck_in(sck_in), .si_in(si_in), .cmd_valid_out(cmd_valid_out),
  .cmd_ready_in(cmd_ready_in), .cmd_out(cmd_out), .busy_out(busy_out),
  .ignored_pulse_out(ignored_pulse_out), .drop_pulse_out(drop_pulse_out));

// *** tb/flash_opcode_decoder_tb.sv ***
// self-checking bench for the opcode decoder
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: decoded value differs", $time); end end
module flash_opcode_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   sys_clk_in = 1'b0;
  logic                   rst_n      = 1'b0;
  logic                   rdy        = 1'b0;
  logic                   rdy_en     = 1'b0;
  logic                   cs_n;
  logic                   sck;
  logic                   si;
  logic                   valid;
  logic                   ign;
  logic                   drop;
  flash_cmd_pkg::decode_t rec;
  logic [16:0]            e;
  logic [16:0]            exp_q[$];
  int                     n_mismatch, total_checks, n_ign, n_exp_ign, n_drop, cyc;
  always #12.5 sys_clk_in = ~sys_clk_in;
  spi_host_model u_host (.clk_in(sys_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
  flash_opcode_decoder #(.FIFO_DEPTH(8)) u_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(rst_n), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .cmd_valid_out(valid), .cmd_ready_in(rdy), .cmd_out(rec),
    .ignored_pulse_out(ign), .drop_pulse_out(drop), .busy_out());
  // packed {class, address length, clock class}
  function automatic logic [8:0] exp_t(input logic [7:0] op);
    logic [8:0] t;
    t = 9'h000;
    for (int i = 0; i < flash_cmd_pkg::OTHER_COUNT; i++)
      if (flash_cmd_pkg::OTHER_OPS[i] == op) t = 9'h133;
    case (op)
      8'h03: t = 9'h014;
      8'h13: t = 9'h018;
      8'h0B: t = 9'h027;
      8'h0C: t = 9'h02B;
      8'h6B: t = 9'h036;
      8'h6C: t = 9'h03A;
      8'hEB: t = 9'h046;
      8'hEC: t = 9'h04A;
      8'hED: t = 9'h055;
      8'hEE: t = 9'h059;
      8'h02: t = 9'h067;
      8'h12: t = 9'h06B;
      8'h32, 8'h38: t = 9'h075;
      8'h34: t = 9'h079;
      8'h20: t = 9'h087;
      8'h21: t = 9'h08B;
      8'hD8: t = 9'h097;
      8'hDC: t = 9'h09B;
      8'h60, 8'hC7: t = 9'h0A3;
      8'h30: t = 9'h0B3;
      8'h43: t = 9'h0C3;
      8'h4A: t = 9'h0D3;
      8'h41: t = 9'h0E3;
      8'h90: t = 9'h0F3;
      8'h9F: t = 9'h103;
      8'hA3: t = 9'h113;
      8'hB9: t = 9'h123;
      8'hAB: t = 9'h130;
      default: ;
    endcase
    return t;
  endfunction : exp_t
  task automatic send(input logic [7:0] op, input int nb, input bit keep);
    logic [8:0] t;
    t = exp_t(op);
    if (nb >= 8 && (t[8:4] == 5'h00 || t[8:4] == 5'h11))
      n_exp_ign++;
    else if (nb >= 8 && keep)
      exp_q.push_back({op, t});
    u_host.frame({op, 8'hA5}, nb);
  endtask : send
  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() != 0; i++)
      @(negedge sys_clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    `CHK(valid, 1'b0)
  endtask : drain
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // random back-pressure on the record sink
  always @(negedge sys_clk_in)
    rdy <= rdy_en && ($urandom() % 3 != 0);
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (ign === 1'b1) n_ign++;
    if (drop === 1'b1) n_drop++;
    if (valid === 1'b1 && rdy === 1'b1)
    begin
      e = (exp_q.size() == 0) ? 17'h1FFFF : exp_q.pop_front();
      `CHK(rec.opcode, e[16:9])
      `CHK({rec.cls, rec.clk}, {e[8:4], e[1:0]})
      `CHK(rec.addr, e[3:2])
    end
    if (cyc == 60000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(68025));
    repeat (12) @(negedge sys_clk_in);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    rdy_en = 1'b1;
    for (int i = 0; i < 256; i++)
      send(i[7:0], 8, 1'b1);
    // short frame yields nothing, trailing bits of a long one are ignored
    send(8'h03, 5, 1'b1);
    send(8'h6C, 12, 1'b1);
    drain();
    rdy_en = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    // eight in the fifo plus one pending, the tenth is lost
    for (int i = 0; i < 10; i++)
      send(8'h0B, 8, i < 9);
    repeat (20) @(negedge sys_clk_in);
    `CHK(n_drop, 1)
    rdy_en = 1'b1;
    drain();
    for (int i = 0; i < 60; i++)
      send(8'($urandom()), 8, 1'b1);
    drain();
    `CHK(n_ign, n_exp_ign)
    stop_test();
  end
endmodule : flash_opcode_decoder_tb
